// file: hdl/decode_defs.svh
`ifndef DECODE_DEFS_SVH
`define DECODE_DEFS_SVH

// ********************************
// instruction fields
// ********************************
`define TOP_BYTE     2'h0
`define TOP_BIT      2'h1
`define TOP_JUMP     2'h2
`define TOP_LIT      2'h3
`define OP_MISC      4'h0
`define OP_CLEAR     4'h1
`define OP_SUB       4'h2
`define OP_DEC       4'h3
`define OP_IOR       4'h4
`define OP_AND       4'h5
`define OP_XOR       4'h6
`define OP_ADD       4'h7
`define OP_MOV       4'h8
`define OP_COM       4'h9
`define OP_INC       4'hA
`define OP_DECSZ     4'hB
`define OP_RR        4'hC
`define OP_RL        4'hD
`define OP_SWAP      4'hE
`define OP_INCSZ     4'hF
`define BIT_CLR      2'h0
`define BIT_SET      2'h1
`define BIT_TSTC     2'h2
`define BIT_TSTS     2'h3
`define LIT_ADD      3'h7
`define LIT_SUB      3'h6
`define LIT_AND      4'h9
`define LIT_IOR      4'h8
`define LIT_XOR      4'hA
`define LIT_LOAD     2'h0
`define LIT_RET      2'h1
`define W_RETURN     14'h0008
`define W_IRET       14'h0009
`define W_KICK       14'h0064
`define W_STANDBY    14'h0063
`define W_IDLE_MASK  14'h009F

// ********************************
// program counter and status
// ********************************
`define IRQ_VECTOR   13'h0004
`define PC_RESET     13'h0000
`define PROGRAM_COUNTER_HIGH_LATCH_RESET 5'h00
`define ST_C         0
`define ST_DC        1
`define ST_Z         2
`define ST_PD        3
`define ST_TO        4
`define STATUS_POR   8'h18
`define Q_LATCH      2'h0
`define Q_READ       2'h1
`define Q_EXEC       2'h3

// ********************************
// timing
// ********************************
`define CLK_MHZ      200
`define WDT_MS       18
`define WDT_CYCLES_DEFAULT (`WDT_MS * 1000 * `CLK_MHZ)

// ********************************
// register bus
// ********************************
`define REG_CTRL     32'h0000_0000
`define REG_STATUS   32'h0000_0004
`define REG_PC       32'h0000_0008
`define CTRL_RUN     0
`define CTRL_GIE     1
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2

`endif

// file: hdl/core_pkg.sv
package core_pkg;

  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic        rready;
  } axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_rsp_t;

  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] wdata;
    logic       we;
  } file_port_t;

  typedef enum logic {MODE_RUN, MODE_SLEEP} run_mode_t;

  typedef struct packed {
    run_mode_t        mode;
    logic [1:0]       phase;
    logic [13:0]      ir;
    logic [7:0]       opnd;
    logic [12:0]      pc;
    logic [4:0]       program_counter_high_latch;
    logic [7:0]       acc;
    logic [7:0]       status;
    logic             flush;
    logic             global_interrupt_allow;
    logic             run;
    logic [7:0][12:0] stack;
    logic [2:0]       sp;
    logic [31:0]      wdt;
    file_port_t       file;
    logic             aw_held;
    logic [31:0]      aw_addr;
    logic             w_held;
    logic [31:0]      w_data;
    logic [3:0]       w_strb;
    axi_rsp_t         rsp;
  } core_state_t;

endpackage

// file: hdl/fourteen_bit_instruction_decode.sv
`timescale 1ns/1ps
`include "decode_defs.svh"

module fourteen_bit_instruction_decode #(
  parameter int unsigned WDT_CYCLES = `WDT_CYCLES_DEFAULT
) (
  // clock and reset
  input  wire logic                sys_clk,
  input  wire logic                rst_b,
  // register bus
  input  wire core_pkg::axi_req_t  axi_req,
  output      core_pkg::axi_rsp_t  axi_rsp,
  // program memory
  output      logic [12:0]         prog_addr,
  input  wire logic [13:0]         instr_word,
  // data register file
  output      core_pkg::file_port_t file_port,
  input  wire logic [7:0]          file_rdata,
  // wake sources
  input  wire logic                irq_req,
  input  wire logic                wake_req
);
  import core_pkg::*;

  if (WDT_CYCLES < 2) begin : g_chk
    $error("WDT_CYCLES must be at least 2");
  end

  localparam core_state_t ST_RESET = '{
    mode: MODE_RUN, phase: `Q_LATCH, ir: 14'h0000, opnd: 8'h00, pc: `PC_RESET,
    program_counter_high_latch: `PROGRAM_COUNTER_HIGH_LATCH_RESET, acc: 8'h00, status: `STATUS_POR, flush: 1'b0, global_interrupt_allow: 1'b0,
    run: 1'b0, stack: '0, sp: 3'h0, wdt: 32'h0000_0000, file: '0, aw_held: 1'b0,
    aw_addr: 32'h0000_0000, w_held: 1'b0, w_data: 32'h0000_0000, w_strb: 4'h0,
    rsp: '{awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0}};

  core_state_t st_reg;
  core_state_t st_next;
  logic        d_exec;
  logic        d_take_irq;
  logic        d_run_op;
  logic        d_skip;
  logic        d_wdt_hit;
  logic [1:0]  top;
  logic [3:0]  op;
  logic [7:0]  k;
  logic [7:0]  f;
  logic [7:0]  w;
  logic [7:0]  res;
  logic [8:0]  r9;
  logic [7:0]  mask;
  logic [12:0] pc_inc;
  logic [31:0] rd;
  logic [1:0]  rresp;

  assign top    = st_reg.ir[13:12];
  assign op     = st_reg.ir[11:8];
  assign k      = st_reg.ir[7:0];
  assign f      = st_reg.opnd;
  assign w      = st_reg.acc;
  assign mask   = 8'h01 << st_reg.ir[9:7];
  assign pc_inc = st_reg.pc + 13'h0001;
  assign d_exec = st_reg.run && (st_reg.mode == MODE_RUN) && (st_reg.phase == `Q_EXEC);
  assign d_take_irq = d_exec && !st_reg.flush && st_reg.global_interrupt_allow && irq_req;
  assign d_run_op   = d_exec && !st_reg.flush && !d_take_irq;
  assign d_wdt_hit  = st_reg.wdt == 32'(WDT_CYCLES - 1);

  // ********************************
  // register read decode
  // ********************************
  always_comb begin
    rd    = 32'h0000_0000;
    rresp = `RESP_OKAY;
    case (axi_req.araddr)
      `REG_CTRL:   rd = {30'h0000_0000, st_reg.global_interrupt_allow, st_reg.run};
      `REG_STATUS: rd = {15'h0000, st_reg.mode == MODE_SLEEP, st_reg.status, st_reg.acc};
      `REG_PC:     rd = {11'h000, st_reg.program_counter_high_latch, 3'h0, st_reg.pc};
      default:     rresp = `RESP_SLVERR;
    endcase
  end

  // ********************************
  // next state
  // ********************************
  always_comb begin
    st_next         = st_reg;
    st_next.file.we = 1'b0;
    res             = 8'h00;
    r9              = 9'h000;
    d_skip          = 1'b0;
    // bus write side
    if (st_reg.rsp.bvalid && axi_req.bready) begin
      st_next.rsp.bvalid = 1'b0;
    end
    if (axi_req.awvalid && st_reg.rsp.awready) begin
      st_next.aw_held = 1'b1;
      st_next.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && st_reg.rsp.wready) begin
      st_next.w_held = 1'b1;
      st_next.w_data = axi_req.wdata;
      st_next.w_strb = axi_req.wstrb;
    end
    if (st_reg.aw_held && st_reg.w_held && !st_reg.rsp.bvalid) begin
      st_next.aw_held    = 1'b0;
      st_next.w_held     = 1'b0;
      st_next.rsp.bvalid = 1'b1;
      st_next.rsp.bresp  = `RESP_OKAY;
      case (st_reg.aw_addr)
        `REG_CTRL: begin
          if (st_reg.w_strb[0]) begin
            st_next.run = st_reg.w_data[`CTRL_RUN];
            st_next.global_interrupt_allow = st_reg.w_data[`CTRL_GIE];
          end
        end
        `REG_STATUS, `REG_PC: st_next.rsp.bresp = `RESP_OKAY;
        default: st_next.rsp.bresp = `RESP_SLVERR;
      endcase
    end
    // bus read side
    if (st_reg.rsp.rvalid && axi_req.rready) begin
      st_next.rsp.rvalid = 1'b0;
    end
    if (axi_req.arvalid && st_reg.rsp.arready) begin
      st_next.rsp.rvalid = 1'b1;
      st_next.rsp.rdata  = rd;
      st_next.rsp.rresp  = rresp;
    end
    // watchdog
    st_next.wdt = st_reg.wdt + 32'h0000_0001;
    // core sequencing
    case (st_reg.mode)
      MODE_SLEEP: begin
        if (irq_req || wake_req || d_wdt_hit) begin
          st_next.mode  = MODE_RUN;
          st_next.phase = `Q_LATCH;
          st_next.flush = 1'b1;
          if (d_wdt_hit) begin
            st_next.status[`ST_TO] = 1'b0;
          end
          if (irq_req && st_reg.global_interrupt_allow) begin
            st_next.stack[st_reg.sp] = st_reg.pc;
            st_next.sp  = st_reg.sp + 3'h1;
            st_next.pc  = `IRQ_VECTOR;
            st_next.global_interrupt_allow = 1'b0;
          end
        end
      end
      MODE_RUN: begin
        if (st_reg.run) begin
          st_next.phase = st_reg.phase + 2'h1;
        end
        if (st_reg.run && st_reg.phase == `Q_LATCH) begin
          st_next.ir        = instr_word;
          st_next.file.addr = instr_word[6:0];
        end
        if (st_reg.run && st_reg.phase == `Q_READ) begin
          st_next.opnd = file_rdata;
        end
        if (d_exec) begin
          // idle second cycle keeps pc on the new target
          if (!st_reg.flush) begin
            st_next.pc = pc_inc;
          end
          st_next.flush = 1'b0;
        end
        if (d_take_irq) begin
          st_next.stack[st_reg.sp] = st_reg.pc;
          st_next.sp    = st_reg.sp + 3'h1;
          st_next.pc    = `IRQ_VECTOR;
          st_next.global_interrupt_allow   = 1'b0;
          st_next.flush = 1'b1;
        end
        if (d_run_op) begin
          case (top)
            `TOP_BYTE: begin
              case (op)
                `OP_ADD: begin
                  r9  = {1'b0, w} + {1'b0, f};
                  res = r9[7:0];
                  st_next.status[`ST_C]  = r9[8];
                  st_next.status[`ST_DC] = ({1'b0, w[3:0]} + {1'b0, f[3:0]}) > 5'h0F;
                end
                `OP_SUB: begin
                  r9  = {1'b0, f} - {1'b0, w};
                  res = r9[7:0];
                  st_next.status[`ST_C]  = !r9[8];
                  st_next.status[`ST_DC] = f[3:0] >= w[3:0];
                end
                `OP_AND:   res = w & f;
                `OP_IOR:   res = w | f;
                `OP_XOR:   res = w ^ f;
                `OP_COM:   res = ~f;
                `OP_DEC:   res = f - 8'h01;
                `OP_INC:   res = f + 8'h01;
                `OP_MOV:   res = f;
                `OP_DECSZ: res = f - 8'h01;
                `OP_INCSZ: res = f + 8'h01;
                `OP_RL: begin
                  res = {f[6:0], st_reg.status[`ST_C]};
                  st_next.status[`ST_C] = f[7];
                end
                `OP_RR: begin
                  res = {st_reg.status[`ST_C], f[7:1]};
                  st_next.status[`ST_C] = f[0];
                end
                `OP_SWAP:  res = {f[3:0], f[7:4]};
                `OP_CLEAR: res = 8'h00;
                `OP_MISC:  res = w;
                default:   res = f;
              endcase
              case (op)
                `OP_ADD, `OP_SUB, `OP_AND, `OP_IOR, `OP_XOR, `OP_COM, `OP_DEC, `OP_INC, `OP_MOV,
                `OP_CLEAR: begin
                  st_next.status[`ST_Z] = res == 8'h00;
                end
                default: st_next.status[`ST_Z] = st_reg.status[`ST_Z];
              endcase
              if ((op == `OP_DECSZ || op == `OP_INCSZ) && res == 8'h00) begin
                d_skip = 1'b1;
              end
              if (op != `OP_MISC || st_reg.ir[7]) begin
                if (st_reg.ir[7]) begin
                  st_next.file.we    = 1'b1;
                  st_next.file.wdata = res;
                end else begin
                  st_next.acc = res;
                end
              end else begin
                case (st_reg.ir)
                  `W_RETURN, `W_IRET: begin
                    st_next.sp    = st_reg.sp - 3'h1;
                    st_next.pc    = st_reg.stack[st_reg.sp - 3'h1];
                    st_next.flush = 1'b1;
                    if (st_reg.ir == `W_IRET) begin
                      st_next.global_interrupt_allow = 1'b1;
                    end
                  end
                  `W_KICK: begin
                    st_next.wdt = 32'h0000_0000;
                    st_next.status[`ST_TO] = 1'b1;
                    st_next.status[`ST_PD] = 1'b1;
                  end
                  `W_STANDBY: begin
                    st_next.wdt  = 32'h0000_0000;
                    st_next.status[`ST_TO] = 1'b1;
                    st_next.status[`ST_PD] = 1'b0;
                    st_next.mode  = MODE_SLEEP;
                    st_next.phase = `Q_LATCH;
                  end
                  default: st_next.acc = st_reg.acc;
                endcase
              end
            end
            `TOP_BIT: begin
              case (st_reg.ir[11:10])
                `BIT_CLR: begin
                  st_next.file.we    = 1'b1;
                  st_next.file.wdata = f & ~mask;
                end
                `BIT_SET: begin
                  st_next.file.we    = 1'b1;
                  st_next.file.wdata = f | mask;
                end
                `BIT_TSTC: d_skip = (f & mask) == 8'h00;
                default:   d_skip = (f & mask) != 8'h00;
              endcase
            end
            `TOP_JUMP: begin
              if (!st_reg.ir[11]) begin
                st_next.stack[st_reg.sp] = pc_inc;
                st_next.sp = st_reg.sp + 3'h1;
              end
              st_next.pc    = {st_reg.program_counter_high_latch[4:3], st_reg.ir[10:0]};
              st_next.flush = 1'b1;
            end
            default: begin
              if (st_reg.ir[11:9] == `LIT_ADD) begin
                r9 = {1'b0, k} + {1'b0, w};
                st_next.status[`ST_DC] = ({1'b0, k[3:0]} + {1'b0, w[3:0]}) > 5'h0F;
                st_next.status[`ST_C]  = r9[8];
              end else if (st_reg.ir[11:9] == `LIT_SUB) begin
                r9 = {1'b0, k} - {1'b0, w};
                st_next.status[`ST_DC] = k[3:0] >= w[3:0];
                st_next.status[`ST_C]  = !r9[8];
              end else if (op == `LIT_AND) begin
                r9 = {1'b0, k & w};
              end else if (op == `LIT_IOR) begin
                r9 = {1'b0, k | w};
              end else if (op == `LIT_XOR) begin
                r9 = {1'b0, k ^ w};
              end else begin
                r9 = {1'b0, k};
              end
              st_next.acc = r9[7:0];
              if (st_reg.ir[11:10] != `LIT_LOAD && st_reg.ir[11:10] != `LIT_RET) begin
                st_next.status[`ST_Z] = r9[7:0] == 8'h00;
              end
              if (st_reg.ir[11:10] == `LIT_RET) begin
                st_next.sp    = st_reg.sp - 3'h1;
                st_next.pc    = st_reg.stack[st_reg.sp - 3'h1];
                st_next.flush = 1'b1;
              end
            end
          endcase
          if (d_skip) begin
            st_next.pc    = st_reg.pc + 13'h0002;
            st_next.flush = 1'b1;
          end
        end
        if (d_wdt_hit) begin
          st_next.pc     = `PC_RESET;
          st_next.program_counter_high_latch = `PROGRAM_COUNTER_HIGH_LATCH_RESET;
          st_next.phase  = `Q_LATCH;
          st_next.flush  = 1'b0;
          st_next.sp     = 3'h0;
          st_next.wdt    = 32'h0000_0000;
          st_next.status[`ST_TO] = 1'b0;
          st_next.status[`ST_PD] = 1'b1;
          st_next.file.we = 1'b0;
        end
      end
      default: st_next.mode = MODE_RUN;
    endcase
    st_next.rsp.awready = !st_next.aw_held && !st_next.rsp.bvalid;
    st_next.rsp.wready  = !st_next.w_held && !st_next.rsp.bvalid;
    st_next.rsp.arready = !st_next.rsp.rvalid;
  end

  // ********************************
  // state register
  // ********************************
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= ST_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign axi_rsp   = st_reg.rsp;
  assign prog_addr = st_reg.pc;
  assign file_port = st_reg.file;

  // ********************************
  // assertions
  // ********************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  sequence s_two_step;
    st_reg.flush ##4 (st_reg.flush == 1'b0);
  endsequence

  property p_add_carry;
    d_run_op && top == `TOP_BYTE && op == `OP_ADD
      |=> st_reg.status[`ST_C] == ($past(st_reg.acc) + {1'b0, $past(st_reg.opnd)} > 9'h0FF);
  endproperty
  a_add_carry: assert property (p_add_carry) else $error("add carry wrong");

  property p_sub_lit;
    d_run_op && top == `TOP_LIT && st_reg.ir[11:9] == `LIT_SUB
      |=> st_reg.status[`ST_C] == ($past(k) >= $past(st_reg.acc)) && st_reg.acc == $past(k - w);
  endproperty
  a_sub_lit: assert property (p_sub_lit) else $error("literal subtract wrong");

  property p_dest_acc;
    d_run_op && top == `TOP_BYTE && op == `OP_AND && !st_reg.ir[7]
      |=> st_reg.acc == ($past(w) & $past(f)) && !st_reg.file.we
          && st_reg.status[`ST_Z] == (st_reg.acc == 8'h00);
  endproperty
  a_dest_acc: assert property (p_dest_acc) else $error("and to acc wrong");

  property p_skip_idle;
    d_run_op && d_skip |=> s_two_step;
  endproperty
  a_skip_idle: assert property (p_skip_idle) else $error("skip not idled");

  property p_jump;
    d_run_op && top == `TOP_JUMP
      |=> st_reg.pc == {$past(st_reg.program_counter_high_latch[4:3]), $past(st_reg.ir[10:0])} && st_reg.flush;
  endproperty
  a_jump: assert property (p_jump) else $error("jump target wrong");

  property p_standby;
    d_run_op && st_reg.ir == `W_STANDBY
      |=> st_reg.mode == MODE_SLEEP && !st_reg.status[`ST_PD] && st_reg.status[`ST_TO] && st_reg.wdt == 32'h0000_0000;
  endproperty
  a_standby: assert property (p_standby) else $error("standby effects wrong");

  property p_kick;
    d_run_op && st_reg.ir == `W_KICK && !d_wdt_hit
      |=> st_reg.status[`ST_PD] && st_reg.status[`ST_TO] && st_reg.mode == MODE_RUN;
  endproperty
  a_kick: assert property (p_kick) else $error("kick effects wrong");

  property p_wake_vector;
    st_reg.mode == MODE_SLEEP && irq_req && st_reg.global_interrupt_allow
      |=> st_reg.pc == `IRQ_VECTOR && st_reg.mode == MODE_RUN && !st_reg.global_interrupt_allow;
  endproperty
  a_wake_vector: assert property (p_wake_vector) else $error("wake vector wrong");

  property p_swap_flags;
    d_run_op && top == `TOP_BYTE && op == `OP_SWAP |=> $stable(st_reg.status);
  endproperty
  a_swap_flags: assert property (p_swap_flags) else $error("swap touched flags");

  property p_clear_acc;
    d_run_op && top == `TOP_BYTE && op == `OP_CLEAR && !st_reg.ir[7]
      |=> st_reg.acc == 8'h00 && st_reg.status[`ST_Z];
  endproperty
  a_clear_acc: assert property (p_clear_acc) else $error("acc clear wrong");

endmodule // fourteen_bit_instruction_decode

// file: sim/prog_mem.sv
`timescale 1ns/1ps
// ****************
// program memory model
// ****************
module prog_mem (
  // fetch port
  input  wire logic [12:0] prog_addr,
  output      logic [13:0] instr_word
);
  logic [13:0] mem [0:15];
  // unloaded space returns a word that follows the address
  assign instr_word = (prog_addr < 13'h0010) ? mem[prog_addr[3:0]] : {1'b1, ~prog_addr};
endmodule // prog_mem

// file: sim/fourteen_bit_instruction_decode_tb.sv
`timescale 1ns/1ps
`include "decode_defs.svh"
// ****************
// testbench
// ****************
module fourteen_bit_instruction_decode_tb;
  import core_pkg::*;
  logic        sys_clk    = 1'b0;
  logic        rst_b      = 1'b0;
  axi_req_t    axi_req    = '0;
  axi_rsp_t    axi_rsp;
  logic [12:0] prog_addr;
  logic [13:0] instr_word;
  file_port_t  file_port;
  logic [31:0] rd;
  logic [1:0]  rr;
  int          n_mismatch = 0;
  int          checks     = 0;
  logic [3:0]  ops [5]    = '{4'hE, 4'hC, 4'h9, 4'h8, 4'hA};
  logic [3:0]  bops [5]   = '{4'h7, 4'h2, 4'h5, 4'hE, 4'hB};
  logic [7:0]  file_rdata = 8'h00;
  logic        wake_req   = 1'b0;

  always #2.5 sys_clk = ~sys_clk;

  fourteen_bit_instruction_decode #(.WDT_CYCLES(200000)) fourteen_bit_instruction_decode_i (
    .sys_clk(sys_clk), .rst_b(rst_b), .axi_req(axi_req), .axi_rsp(axi_rsp),
    .prog_addr(prog_addr), .instr_word(instr_word), .file_port(file_port),
    .file_rdata(file_rdata), .irq_req(1'b0), .wake_req(wake_req));
  prog_mem prog_mem_i (.prog_addr(prog_addr), .instr_word(instr_word));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
    logic aw;
    logic w;
    aw = 1'b0;
    w = 1'b0;
    axi_req.awvalid <= 1'b1; axi_req.awaddr <= a; axi_req.wvalid <= 1'b1;
    axi_req.wdata <= d; axi_req.wstrb <= 4'hF; axi_req.bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge sys_clk);
      if (axi_rsp.awready) begin aw = 1'b1; axi_req.awvalid <= 1'b0; end
      if (axi_rsp.wready) begin w = 1'b1; axi_req.wvalid <= 1'b0; end
    end
    while (!axi_rsp.bvalid) @(posedge sys_clk);
    axi_req.bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [31:0] a);
    axi_req.arvalid <= 1'b1; axi_req.araddr <= a; axi_req.rready <= 1'b1;
    do @(posedge sys_clk); while (!axi_rsp.arready);
    axi_req.arvalid <= 1'b0;
    do @(posedge sys_clk); while (!axi_rsp.rvalid);
    rd = axi_rsp.rdata;
    rr = axi_rsp.rresp;
  endtask

  // status and acc after load_literal w then word iw, file reading f
  function automatic logic [15:0] expect_alu(input logic [13:0] iw, input logic [7:0] w, input logic [7:0] f);
    logic [8:0] r;
    logic [7:0] a;
    logic       dc;
    logic       zf;
    a  = iw[13] ? iw[7:0] : f;
    dc = 1'b0;
    zf = 1'b1;
    case ({iw[13], iw[11:8]})
      5'h1E, 5'h07: begin r = {1'b0, a} + {1'b0, w}; dc = (a[3:0] + w[3:0]) > 5'h0F; end
      5'h1C, 5'h02: begin r = {1'b0, a} - {1'b0, w}; r[8] = ~r[8]; dc = a[3:0] >= w[3:0]; end
      5'h19, 5'h05: r = {1'b0, a & w};
      5'h18:        r = {1'b0, a | w};
      5'h01:        r = 9'h000;
      5'h0E:        begin r = {1'b0, a[3:0], a[7:4]}; zf = 1'b0; end
      5'h0B:        begin r = {1'b0, a - 8'h01}; zf = 1'b0; end
      5'h00:        begin r = {1'b0, w}; zf = 1'b0; end
      default:      r = {1'b0, a ^ w};
    endcase
    return {3'b000, 1'b1, iw != 14'h0063, zf && r[7:0] == 8'h00, dc, r[8], r[7:0]};
  endfunction

  task automatic run(input logic [13:0] iw, input logic [7:0] w, input logic [7:0] fv);
    rst_b      <= 1'b0;
    file_rdata <= fv;
    wake_req   <= iw == 14'h0063;
    prog_mem_i.mem[0] = {6'b110000, w};
    prog_mem_i.mem[1] = iw;
    prog_mem_i.mem[2] = 14'h0000;
    prog_mem_i.mem[3] = 14'h2803;
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    axi_rd(`REG_STATUS); chk({15'h0, rd[16:0]}, 32'h0000_1800);
    axi_rd(`REG_PC); chk({11'h0, rd[20:0]}, 32'h0000_0000);
    axi_wr(`REG_CTRL, 32'h0000_0001);
    do axi_rd(`REG_PC); while (rd[12:0] !== 13'h0003);
    axi_rd(`REG_STATUS); chk({16'h0, rd[15:0]}, {16'h0, expect_alu(iw, w, fv)});
    axi_rd(`REG_PC); chk({11'h0, rd[20:0]}, 32'h0000_0003);
    $display("test word %h w %h f %h done", iw, w, fv);
  endtask

  initial begin
    void'($urandom(13));
    foreach (ops[i]) begin
      run({2'b11, ops[i], 8'h02}, 8'h02, 8'h00);
      run({2'b11, ops[i], 8'h02}, 8'h03, 8'h00);
      repeat (4) run({2'b11, ops[i], 8'($urandom)}, 8'($urandom), 8'($urandom));
    end
    foreach (bops[i]) begin
      repeat (4) run({2'b00, bops[i], 1'b0, 7'($urandom)}, 8'($urandom), 8'($urandom));
    end
    // corner cases: skip on zero, clear acc, kick, standby with wake
    run(14'h0B00, 8'h07, 8'h01);
    run(14'h0100, 8'h5A, 8'h00);
    run(14'h0064, 8'h33, 8'h00);
    run(14'h0063, 8'h44, 8'h00);
    axi_rd(32'h0000_0010); chk({30'h0, rr}, {30'h0, `RESP_SLVERR});
    $display("test unmapped read done");
    end_of_test();
  end

  initial begin
    repeat (40000) @(posedge sys_clk);
    n_mismatch++;
    end_of_test();
  end
endmodule // fourteen_bit_instruction_decode_tb
